/* logic/isd_pkg.sv */
package isd_pkg;
    // instruction codes served by this block
    localparam logic [7:0]  CMD_IDENTITY = 8'h02;   // fetch_identity_cmd
    localparam logic [7:0]  CMD_STATUS   = 8'h03;   // status word read
    localparam logic [7:0]  CMD_ENTER    = 8'h04;   // enter_programming_cmd
    localparam logic [7:0]  CMD_EXIT     = 8'h05;   // back to user mode
    localparam logic [15:0] UNLOCK_KEY   = 16'hE53D; // programming_unlock_key
    localparam logic [7:0]  NOOP_DATA    = 8'hFF;   // read data of unserved codes
    // write byte counts at stop, address byte included
    localparam logic [2:0]  CNT_EXIT     = 3'h2;
    localparam logic [2:0]  CNT_ENTER    = 3'h4;
    localparam logic [3:0]  BITS_BYTE    = 4'h8;
    // status word field positions
    localparam int POS_CRC_FAIL  = 7;
    localparam int POS_CFG_DONE  = 6;
    localparam int POS_ADDR_DONE = 5;
    localparam int POS_PROG      = 4;
    localparam int POS_SHADOW    = 2;
    localparam int POS_ERASE     = 0;
    localparam int POS_PGM_BUSY  = 15;
    localparam int POS_WIPE      = 14;
    localparam int POS_LOG_WR    = 13;
    localparam int POS_LOG_FULL  = 12;
    localparam int POS_ROW_LO    = 8;
    localparam logic [15:0] STATUS_RST = 16'h0000; // status after reset

    // instruction groups
    typedef enum logic [2:0] {
        grp_reserved, grp_status_mode, grp_config, grp_trim, grp_meas, grp_tag, grp_log
    } isd_group_type;

    // state reported by the surrounding device
    typedef struct packed {
        logic       crc_fail_evt;    // backup image check mismatch, pulse
        logic       dualboot_start;  // dual-boot config write begins, pulse
        logic       cfg_done;        // config array done bit, level
        logic       addr_done;       // bus address done bit, level
        logic       shadow_copy_evt; // eeprom copied to shadows, pulse
        logic       erase_busy;      // any eeprom erase running
        logic       program_busy;    // any eeprom program running
        logic       wipe_busy;       // log or tag erase running
        logic       log_write_busy;  // fault data being written
        logic       log_full;        // all log rows written
        logic [3:0] last_row;        // last written log row
    } isd_stat_in_type;
endpackage : isd_pkg

/* logic/isd_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module isd_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_i,   // system clock
    input  wire logic             rst_n_i, // async reset, active low
    input  wire logic [WIDTH-1:0] d_i,     // asynchronous inputs
    output logic      [WIDTH-1:0] q_o      // synchronised outputs
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by second
    logic [WIDTH-1:0] q_reg;    // second stage

    // reset high: an idle bus is released
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '1;
            q_reg    <= '1;
        end
        else
        begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule : isd_sync

/* logic/isd_cmd_decode.sv */
`timescale 1ns/1ps
// sorts an instruction code into its group
module isd_cmd_decode (
    input  wire logic [7:0]           code_i,  // instruction code
    output isd_pkg::isd_group_type    group_o  // decoded group
);
    // range decode of the instruction space
    function automatic isd_pkg::isd_group_type decode(input logic [7:0] c);
        if (c >= 8'h02 && c <= 8'h05)
            return isd_pkg::grp_status_mode;
        else if (c == 8'h25 || (c >= 8'h31 && c <= 8'h35))
            return isd_pkg::grp_config;
        else if (c >= 8'h41 && c <= 8'h44)
            return isd_pkg::grp_trim;
        else if (c >= 8'h51 && c <= 8'h52)
            return isd_pkg::grp_meas;
        else if (c >= 8'h61 && c <= 8'h65)
            return isd_pkg::grp_tag;
        else if (c == 8'h71 || (c >= 8'h73 && c <= 8'h76))
            return isd_pkg::grp_log;
        else
            return isd_pkg::grp_reserved;
    endfunction : decode

    assign group_o = decode(code_i);
endmodule : isd_cmd_decode

/* logic/isd_top.sv */
`timescale 1ns/1ps
module isd_top #(
    parameter logic [7:0] ID_CODE = 8'h5A // arbitrary identity value
) (
    input  wire logic                     clk_i,         // 50 MHz system clock
    input  wire logic                     rst_n_i,       // async reset, active low
    input  wire logic                     scl_i,         // bus clock pin
    input  wire logic                     sda_i,         // bus data pin, input side
    output logic                          sda_o,         // bus data drive value
    output logic                          sda_oe_o,      // high while pulling data low
    input  wire logic [3:0]               addr_hi_i,     // configured address bits
    input  wire logic [2:0]               addr_strap_i,  // sensed strap address bits
    input  isd_pkg::isd_stat_in_type      stat_i,        // device state, same clock
    output logic                          programming_active_o,   // programming_active
    output logic [15:0]                   status_word_o, // device_state_word
    output isd_pkg::isd_group_type        cmd_group_o,   // group of last code
    output logic                          cmd_strobe_o   // pulse: code received
);
    typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_txack} isd_state_type;

    logic [1:0]               pin_s;          // synchronised scl, sda
    logic                     scl_s, sda_s;   // synchronised pins
    logic [2:0]               strap_s;        // synchronised strap
    logic                     scl_q_reg, sda_q_reg; // previous samples
    logic                     scl_rise, scl_fall, bus_start, bus_stop;
    isd_state_type            state_reg, state_next;
    logic [3:0]               bit_reg, bit_next;      // bit counter
    logic [7:0]               shift_reg, shift_next;  // receive shifter
    logic [7:0]               tx_reg, tx_next;        // transmit shifter
    logic [2:0]               cnt_reg, cnt_next;      // write bytes seen
    logic                     rw_reg, rw_next;        // read phase
    logic [7:0]               cmd_reg, cmd_next;      // current code
    logic [15:0]              key_reg, key_next;      // key bytes
    logic                     idx_reg, idx_next;      // read byte index
    logic                     oe_reg, oe_next;        // data pull-down
    logic                     prog_reg, prog_next;    // programming mode
    isd_pkg::isd_group_type   group_reg, group_next, group_dec;
    logic                     strobe_reg, strobe_next;
    logic                     crc_reg, crc_next;      // sticky check fail
    logic                     shadow_reg, shadow_next; // sticky copy flag
    logic                     shadow_clr;             // status low byte sent
    logic [15:0]              status_reg, status_next;
    logic                     addr_hit;

    // pins come from the bus clock domain, two flops first
    isd_sync #(.WIDTH(2)) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({scl_i, sda_i}),
        .q_o     (pin_s)
    );
    // strap pin is static but still asynchronous
    isd_sync #(.WIDTH(3)) u_strap_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (addr_strap_i),
        .q_o     (strap_s)
    );
    isd_cmd_decode u_decode (
        .code_i  (shift_reg),
        .group_o (group_dec)
    );

    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];
    // bus conditions from synchronised samples
    assign scl_rise  = scl_s & ~scl_q_reg;
    assign scl_fall  = ~scl_s & scl_q_reg;
    assign bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
    assign addr_hit  = (shift_reg[7:1] == {addr_hi_i, strap_s});

    // byte served on a read, by code and position
    function automatic logic [7:0] read_byte(input logic [7:0] c, input logic i,
                                             input logic [15:0] s);
        if (c == isd_pkg::CMD_IDENTITY)
            return ID_CODE;
        else if (c == isd_pkg::CMD_STATUS)
            return i ? s[15:8] : s[7:0];
        else
            return isd_pkg::NOOP_DATA;
    endfunction : read_byte

    // bus engine and mode control, next values
    always_comb
    begin
        state_next  = state_reg;
        bit_next    = bit_reg;
        shift_next  = shift_reg;
        tx_next     = tx_reg;
        cnt_next    = cnt_reg;
        rw_next     = rw_reg;
        cmd_next    = cmd_reg;
        key_next    = key_reg;
        idx_next    = idx_reg;
        oe_next     = oe_reg;
        prog_next   = prog_reg;
        group_next  = group_reg;
        strobe_next = 1'b0;
        shadow_clr  = 1'b0;
        if (bus_start)
        begin
            // plain or repeated start, the code survives
            state_next = st_rx;
            bit_next   = 4'h0;
            cnt_next   = 3'h0;
            oe_next    = 1'b0;
        end
        else if (bus_stop)
        begin
            // mode changes only take effect at the stop
            state_next = st_idle;
            oe_next    = 1'b0;
            if (!rw_reg && cmd_reg == isd_pkg::CMD_ENTER && cnt_reg == isd_pkg::CNT_ENTER
                && key_reg == isd_pkg::UNLOCK_KEY)
                prog_next = 1'b1;
            if (!rw_reg && cmd_reg == isd_pkg::CMD_EXIT && cnt_reg == isd_pkg::CNT_EXIT)
                prog_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                st_rx:
                begin
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_next   = bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == isd_pkg::BITS_BYTE)
                    begin
                        state_next = st_ack;
                        oe_next    = 1'b1;
                        bit_next   = 4'h0;
                        idx_next   = 1'b0;
                        if (cnt_reg == 3'h0)
                        begin
                            rw_next = shift_reg[0];
                            if (!addr_hit)
                            begin
                                // not ours: stay off the bus until next start
                                state_next = st_idle;
                                oe_next    = 1'b0;
                            end
                        end
                        else if (cnt_reg == 3'h1)
                        begin
                            cmd_next    = shift_reg;
                            group_next  = group_dec;
                            strobe_next = 1'b1;
                        end
                        else if (cnt_reg == 3'h2)
                            key_next[7:0] = shift_reg;
                        else if (cnt_reg == 3'h3)
                            key_next[15:8] = shift_reg;
                        // saturate so extra bytes spoil the key count
                        if (cnt_reg != 3'h7 && (cnt_reg != 3'h0 || addr_hit))
                            cnt_next = cnt_reg + 3'h1;
                    end
                end
                st_ack:
                begin
                    // ack held until the next bus clock fall; also entered after a master ack
                    if (scl_fall)
                    begin
                        if (rw_reg)
                        begin
                            tx_next    = read_byte(cmd_reg, idx_reg, status_reg);
                            oe_next    = ~tx_next[7];
                            idx_next   = 1'b1;
                            bit_next   = 4'h0;
                            state_next = st_tx;
                            shadow_clr = (cmd_reg == isd_pkg::CMD_STATUS) && !idx_reg;
                        end
                        else
                        begin
                            oe_next    = 1'b0;
                            state_next = st_rx;
                        end
                    end
                end
                st_tx:
                begin
                    if (scl_fall)
                    begin
                        if (bit_reg == 4'h7)
                        begin
                            oe_next    = 1'b0;
                            state_next = st_txack;
                        end
                        else
                        begin
                            tx_next  = {tx_reg[6:0], 1'b1};
                            oe_next  = ~tx_reg[6];
                            bit_next = bit_reg + 4'h1;
                        end
                    end
                end
                st_txack:
                begin
                    if (scl_rise)
                        state_next = sda_s ? st_idle : st_ack;
                end
                default:
                    state_next = st_idle;
            endcase
        end
    end

    // status word, next values
    always_comb
    begin
        crc_next = stat_i.dualboot_start ? 1'b0 : crc_reg;
        if (stat_i.crc_fail_evt)
            crc_next = 1'b1;
        shadow_next = shadow_clr ? 1'b0 : shadow_reg;
        if (stat_i.shadow_copy_evt)
            shadow_next = 1'b1;
        status_next = isd_pkg::STATUS_RST;                     // reserved bits zero
        status_next[isd_pkg::POS_CRC_FAIL]  = crc_reg;
        status_next[isd_pkg::POS_CFG_DONE]  = stat_i.cfg_done;
        status_next[isd_pkg::POS_ADDR_DONE] = stat_i.addr_done;
        status_next[isd_pkg::POS_PROG]      = prog_reg;
        status_next[isd_pkg::POS_SHADOW]    = shadow_reg;
        status_next[isd_pkg::POS_ERASE]     = stat_i.erase_busy;
        status_next[isd_pkg::POS_PGM_BUSY]  = stat_i.program_busy;
        status_next[isd_pkg::POS_WIPE]      = stat_i.wipe_busy;
        status_next[isd_pkg::POS_LOG_WR]    = stat_i.log_write_busy;
        status_next[isd_pkg::POS_LOG_FULL]  = stat_i.log_full;
        status_next[isd_pkg::POS_ROW_LO +: 4] = stat_i.last_row;
    end

    // all state registered here
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_q_reg  <= 1'b1;
            sda_q_reg  <= 1'b1;
            state_reg  <= st_idle;
            bit_reg    <= 4'h0;
            shift_reg  <= 8'h00;
            tx_reg     <= 8'hFF;
            cnt_reg    <= 3'h0;
            rw_reg     <= 1'b0;
            cmd_reg    <= 8'h00;
            key_reg    <= 16'h0000;
            idx_reg    <= 1'b0;
            oe_reg     <= 1'b0;
            prog_reg   <= 1'b0;
            group_reg  <= isd_pkg::grp_reserved;
            strobe_reg <= 1'b0;
            crc_reg    <= 1'b0;
            shadow_reg <= 1'b0;
            status_reg <= isd_pkg::STATUS_RST;
        end
        else
        begin
            scl_q_reg  <= scl_s;
            sda_q_reg  <= sda_s;
            state_reg  <= state_next;
            bit_reg    <= bit_next;
            shift_reg  <= shift_next;
            tx_reg     <= tx_next;
            cnt_reg    <= cnt_next;
            rw_reg     <= rw_next;
            cmd_reg    <= cmd_next;
            key_reg    <= key_next;
            idx_reg    <= idx_next;
            oe_reg     <= oe_next;
            prog_reg   <= prog_next;
            group_reg  <= group_next;
            strobe_reg <= strobe_next;
            crc_reg    <= crc_next;
            shadow_reg <= shadow_next;
            status_reg <= status_next;
        end
    end

    // open-drain: the drive value is always low
    assign sda_o         = 1'b0;
    assign sda_oe_o      = oe_reg;
    assign programming_active_o   = prog_reg;
    assign status_word_o = status_reg;
    assign cmd_group_o   = group_reg;
    assign cmd_strobe_o  = strobe_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_key_enter: assert property (bus_stop && !rw_reg && cmd_reg == isd_pkg::CMD_ENTER
        && cnt_reg == isd_pkg::CNT_ENTER && key_reg == isd_pkg::UNLOCK_KEY |=> prog_reg)
        else $error("good key did not enter programming");
    a_exit_user: assert property (bus_stop && !rw_reg && cmd_reg == isd_pkg::CMD_EXIT
        && cnt_reg == isd_pkg::CNT_EXIT |=> !prog_reg)
        else $error("exit code did not leave programming");
    a_mode_only_stop: assert property ($changed(prog_reg) |-> $past(bus_stop))
        else $error("mode changed outside a stop");
    a_mode_status: assert property (##1 status_word_o[4] == $past(prog_reg))
        else $error("status mode bit wrong");
    a_crc_flag: assert property (stat_i.crc_fail_evt |-> ##2 status_word_o[7])
        else $error("check fail not reported");
    a_shadow_flag: assert property (stat_i.shadow_copy_evt |-> ##2 status_word_o[2])
        else $error("shadow copy not reported");
    a_busy_pass: assert property (##1 status_word_o[15:12] == $past({stat_i.program_busy,
        stat_i.wipe_busy, stat_i.log_write_busy, stat_i.log_full}))
        else $error("busy flags wrong");
    a_addr_miss: assert property (state_reg == st_rx && scl_fall && bit_reg == 4'h8
        && cnt_reg == 3'h0 && !addr_hit && !bus_start && !bus_stop
        |=> state_reg == st_idle && !sda_oe_o)
        else $error("foreign address acknowledged");
    a_reserved_ones: assert property (state_reg == st_ack && rw_reg && scl_fall
        && !bus_start && !bus_stop && group_reg == isd_pkg::grp_reserved |=> tx_reg == 8'hFF)
        else $error("reserved read not all ones");
    a_identity: assert property (state_reg == st_ack && rw_reg && scl_fall
        && !bus_start && !bus_stop && cmd_reg == isd_pkg::CMD_IDENTITY |=> tx_reg == ID_CODE)
        else $error("identity byte wrong");

    c_enter: cover property (bus_stop ##1 $rose(prog_reg));
    c_exit: cover property (bus_stop ##1 $fell(prog_reg));
    c_status: cover property (shadow_clr);
    c_ident: cover property (state_reg == st_tx && cmd_reg == isd_pkg::CMD_IDENTITY);
endmodule : isd_top

/* testbench/isd_master.sv */
`timescale 1ns/1ps
// bus master model; the bus clock rests high outside frames
module isd_master (
    input  wire logic  clk_i,              // system clock
    input  wire logic  sda_i,              // resolved data wire
    output logic       scl_o = 1'b1,       // bus clock, 160 ns period
    output logic       sda_low_o = 1'b0,   // high while pulling data low
    output logic [7:0] res_o = 8'h00,      // read byte, or ack bit in bit 0
    output logic       done_o = 1'b0       // pulse after each byte
);
    // start (a=0) or stop (a=1); long low phase so a late ack release
    // never looks like a stop; no stop before a read phase
    task automatic phase(input logic a, input logic b);
        @(negedge clk_i) sda_low_o = a;
        repeat (7) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (4) @(negedge clk_i);
        sda_low_o = b;
        repeat (4) @(negedge clk_i);
        scl_o = a;
    endtask : phase
    // eight bits msb first, then the ack bit; a9=1 on the last read byte
    task automatic xbyte(input logic [7:0] wb, input logic a9, input logic rd);
        logic [8:0] w;
        logic [8:0] r;
        w = {wb, a9};
        for (int i = 8; i >= 0; i--)
        begin
            @(negedge clk_i) sda_low_o = ~w[i];
            repeat (3) @(negedge clk_i);
            scl_o = 1'b1;
            repeat (4) @(negedge clk_i);
            r[i] = sda_i;
            scl_o = 1'b0;
        end
        res_o = rd ? r[8:1] : {7'h00, r[0]};
        done_o = 1'b1;
        @(negedge clk_i) done_o = 1'b0;
    endtask : xbyte
endmodule : isd_master

/* testbench/tb.sv */
`timescale 1ns/1ps
// self-checking bench: bytes and groups are queued, monitors compare
module tb;
    localparam logic [7:0] ID = 8'hA7; // arbitrary identity value
    localparam logic [7:0] AW = 8'hCA; // upper bits 0xC, strap 5, write
    logic                     clk_i = 1'b0;
    logic                     rst_n_i = 1'b0;
    logic                     scl;
    logic                     sda_low;
    logic                     sda_oe_o;
    logic                     sda_drv;
    logic                     programming_active_o;
    logic                     cmd_strobe_o;
    logic                     done;
    logic [7:0]               res;
    logic [15:0]              w;
    logic [15:0]              status_word_o;
    isd_pkg::isd_stat_in_type st = '0;
    isd_pkg::isd_group_type   cmd_group_o;
    logic [7:0]               eq[$];
    isd_pkg::isd_group_type   gq[$];
    int                       n_fail = 0;
    int                       comparisons = 0;
    // codes at each group's range ends except 05, and just past each upper end, to check the group decode
    logic [7:0]               codes[25] = '{8'h01, 8'h02, 8'h03, 8'hFF, 8'h06, 8'h24, 8'h25,
        8'h26, 8'h31, 8'h35, 8'h36, 8'h41, 8'h44, 8'h45, 8'h51, 8'h52, 8'h53, 8'h61, 8'h65,
        8'h66, 8'h71, 8'h72, 8'h73, 8'h76, 8'h77};
    // pull-up when released; device pulls low only when its drive value is 0
    wire                      sda = ~(sda_low | (sda_oe_o & ~sda_drv));
    isd_top #(.ID_CODE(ID)) u_isd_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe_o), .addr_hi_i(4'hC), .addr_strap_i(3'h5),
        .stat_i(st), .programming_active_o(programming_active_o), .status_word_o(status_word_o),
        .cmd_group_o(cmd_group_o), .cmd_strobe_o(cmd_strobe_o));
    isd_master u_isd_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
        .res_o(res), .done_o(done));
    initial
        forever #10 clk_i = ~clk_i;
    function automatic isd_pkg::isd_group_type grp(input logic [7:0] c);
        if (c >= 8'h02 && c <= 8'h05) return isd_pkg::grp_status_mode;
        if (c == 8'h25 || (c >= 8'h31 && c <= 8'h35)) return isd_pkg::grp_config;
        if (c >= 8'h41 && c <= 8'h44) return isd_pkg::grp_trim;
        if (c == 8'h51 || c == 8'h52) return isd_pkg::grp_meas;
        if (c >= 8'h61 && c <= 8'h65) return isd_pkg::grp_tag;
        if (c == 8'h71 || (c >= 8'h73 && c <= 8'h76)) return isd_pkg::grp_log;
        return isd_pkg::grp_reserved;
    endfunction : grp
    // status word from the state levels and the three flags
    function automatic logic [15:0] sw(input logic c, input logic p, input logic s);
        return {st.program_busy, st.wipe_busy, st.log_write_busy, st.log_full, st.last_row,
            c, st.cfg_done, st.addr_done, p, 1'b0, s, 1'b0, st.erase_busy};
    endfunction : sw
    task automatic fail(input string m);
        n_fail++;
        $display("Error at %0t: %s", $time, m);
    endtask : fail
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) fail("output value differs");
    endtask : cmp
    // one byte through the master, expected ack or data queued first
    task automatic bt(input logic [7:0] b, input logic a9, input logic rd, input logic [7:0] e);
        eq.push_back(e);
        u_isd_master.xbyte(b, a9, rd);
    endtask : bt
    task automatic cmd(input logic [7:0] c);
        u_isd_master.phase(1'b0, 1'b1);
        bt(AW, 1'b1, 1'b0, 8'h00);
        gq.push_back(grp(c));
        bt(c, 1'b1, 1'b0, 8'h00);
    endtask : cmd
    // enter attempt; mode only changes with the whole key
    task automatic key(input logic [7:0] hi, input logic full, input logic e);
        cmd(isd_pkg::CMD_ENTER);
        bt(8'h3D, 1'b1, 1'b0, 8'h00);
        if (full) bt(hi, 1'b1, 1'b0, 8'h00);
        u_isd_master.phase(1'b1, 1'b0);
        repeat (3) @(negedge clk_i);
        cmp(16'(programming_active_o), 16'(e));
    endtask : key
    // one-cycle event pulse on the state input
    task automatic evt(input logic [13:0] m);
        @(negedge clk_i) st = st | m;
        @(negedge clk_i) st = st & ~m;
        repeat (3) @(negedge clk_i);
    endtask : evt
    task automatic test_done();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    always @(posedge done)
    begin
        comparisons++;
        if (res !== eq.pop_front()) fail("bus byte or ack differs");
    end
    // sampled mid-cycle, away from the edge that launches the strobe
    always @(negedge clk_i)
        if (cmd_strobe_o === 1'b1)
        begin
            comparisons++;
            if (cmd_group_o !== gq.pop_front()) fail("instruction group differs");
        end
    initial
    begin
        repeat (100000) @(posedge clk_i);
        fail("run did not finish");
        test_done();
    end
    initial
    begin
        void'($urandom(66274));
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        // random levels, event pulses masked off
        repeat (4)
        begin
            @(negedge clk_i) st = 14'($urandom) & 14'h0DFF;
            repeat (3) @(negedge clk_i);
            cmp(status_word_o, sw(1'b0, 1'b0, 1'b0));
        end
        foreach (codes[i])
        begin
            cmd(codes[i]);
            u_isd_master.phase(1'b1, 1'b0);
        end
        // foreign address must not be acknowledged
        u_isd_master.phase(1'b0, 1'b1);
        bt(8'hC8, 1'b1, 1'b0, 8'h01);
        u_isd_master.phase(1'b1, 1'b0);
        key(8'hE4, 1'b1, 1'b0);
        key(8'hE5, 1'b0, 1'b0);
        key(8'hE5, 1'b1, 1'b1);
        cmp(status_word_o, sw(1'b0, 1'b1, 1'b0));
        cmd(isd_pkg::CMD_EXIT);
        u_isd_master.phase(1'b1, 1'b0);
        repeat (3) @(negedge clk_i);
        cmp(16'(programming_active_o), 16'h0000);
        cmd(isd_pkg::CMD_IDENTITY);
        u_isd_master.phase(1'b0, 1'b1);
        bt(AW | 8'h01, 1'b1, 1'b0, 8'h00);
        bt(8'hFF, 1'b1, 1'b1, ID);
        u_isd_master.phase(1'b1, 1'b0);
        evt(14'h2200);
        w = sw(1'b1, 1'b0, 1'b1);
        cmd(isd_pkg::CMD_STATUS);
        u_isd_master.phase(1'b0, 1'b1);
        bt(AW | 8'h01, 1'b1, 1'b0, 8'h00);
        bt(8'hFF, 1'b0, 1'b1, w[7:0]);
        bt(8'hFF, 1'b1, 1'b1, w[15:8]);
        u_isd_master.phase(1'b1, 1'b0);
        cmp(status_word_o, sw(1'b1, 1'b0, 1'b0));
        evt(14'h1000);
        cmp(status_word_o, sw(1'b0, 1'b0, 1'b0));
        cmd(8'h66);
        u_isd_master.phase(1'b0, 1'b1);
        bt(AW | 8'h01, 1'b1, 1'b0, 8'h00);
        bt(8'hFF, 1'b1, 1'b1, 8'hFF);
        u_isd_master.phase(1'b1, 1'b0);
        test_done();
    end
endmodule : tb
